/* File: logic/cfs_select.sv */
// Top of the creep and fixed-setpoint selector with its register port.
// Assumes the ramp generator and on/off sequencer sit outside and report
// their state as synchronous levels; all inputs except sys_rst are synchronous to clk_sys.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cfs_select (
  input  wire logic                          clk_sys,              // System clock.
  input  wire logic                          sys_rst,              // Async reset, active high.
  // Register port.
  input  wire logic [7:0]                    reg_addr,             // Byte address.
  input  wire logic [31:0]                   reg_wdata,            // Write data.
  input  wire logic                          reg_wr,               // Write strobe.
  input  wire logic                          reg_rd,               // Read strobe.
  output logic      [31:0]                   reg_rdata,            // Read data, next cycle.
  // Binary sources.
  input  wire logic [cfs_pkg::N_CREEP-1:0]   creep_src,            // Creep sources.
  input  wire logic [cfs_pkg::N_CREEP-1:0]   creep_permit_in,      // Permit candidates.
  input  wire logic [cfs_pkg::N_IDX-1:0]     fixed_src_idx,        // Indexed fixed sources.
  input  wire logic                          extra_fixed_source_a, // Extra fixed source.
  input  wire logic                          extra_fixed_source_b, // Extra fixed source.
  input  wire logic [cfs_pkg::SP_W-1:0]      main_setpoint_input,  // Main setpoint.
  // Sequencer status.
  input  wire logic                          switched_off_ready_state, // Drive off and ready.
  input  wire logic                          drive_running,        // Operation state.
  input  wire logic                          operation_enable,     // Operation enable.
  input  wire logic                          switch_on_cmd,        // External switch-on.
  input  wire logic                          below_min_speed,      // Speed under minimum.
  // Outputs to ramp and sequencer.
  output logic      [cfs_pkg::SP_W-1:0]      setpoint_out,         // Selected setpoint.
  output logic                               ramp_bypass,          // Zero ramp times.
  output logic                               creep_switch_on,      // Switch-on request.
  output logic                               ctrl_disable,         // Controller disable.
  output logic                               contactor_open,       // Open line contactor.
  output logic                               creep_active          // Creep setpoint in use.
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                                        creep_trigger_mode;
    logic [1:0]                                  creep_latch_permit_select;
    logic [cfs_pkg::N_CREEP-1:0]                 creep_source_select;
    logic [cfs_pkg::N_FIX-1:0]                   setpoint_source_select;
    logic [cfs_pkg::N_FIX-1:0]                   fixed_ramp_bypass_select;
    logic [cfs_pkg::N_CREEP-1:0][cfs_pkg::SP_W-1:0] creep_values;
    logic [cfs_pkg::N_FIX-1:0][cfs_pkg::SP_W-1:0]   fixed_setpoint_values;
    logic [7:0]                                  tick_cnt;
    logic [cfs_pkg::N_FIX-1:0]                   fix_mask;
    cfs_pkg::cfs_state_e                         state;
    logic [cfs_pkg::SP_W-1:0]                    setpoint;
    logic                                        bypass;
    logic                                        swon;
    logic                                        disable_ctl;
    logic                                        open_k;
    logic [31:0]                                 rdata;
  } cfs_top_s;

  cfs_top_s st_reg;
  cfs_top_s st_next;

  logic                        tick;
  logic                        permit;
  logic [cfs_pkg::N_CREEP-1:0] creep_mask;
  logic                        creep_req;
  logic [cfs_pkg::N_FIX-1:0]   fix_src;
  logic [cfs_pkg::SP_W-1:0]    creep_sum;
  logic [cfs_pkg::SP_W-1:0]    fix_sum;
  logic                        fix_on;
  logic                        creep_ok;
  logic [cfs_pkg::N_FIX-1:0]   fix_live;

  // Index of an address inside a word table, or all ones when outside.
  function automatic logic [3:0] tbl_index(input logic [7:0] addr,
                                           input logic [7:0] base,
                                           input logic [3:0] count);
    logic [7:0] off;
    off = addr - base;
    if (addr >= base && off[1:0] == 2'b00 && off[7:2] < {2'b00, count})
      tbl_index = off[5:2];
    else
      tbl_index = 4'hF;
  endfunction

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  assign tick    = (st_reg.tick_cnt == cfs_pkg::SAMPLE_LAST);
  assign permit  = creep_permit_in[st_reg.creep_latch_permit_select];
  assign fix_src = {extra_fixed_source_b, extra_fixed_source_a, fixed_src_idx};
  // The fixed sum is built from this tick's sources, so the value and the switch move together.
  assign fix_live = fix_src & st_reg.setpoint_source_select;
  assign creep_req = |creep_mask;
  assign fix_on  = |st_reg.fix_mask;
  // Creep may only start from off-ready or running, never without enable.
  assign creep_ok = operation_enable && (switched_off_ready_state || drive_running);

  cfs_creep_req u_creep (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick),
    .mode    (st_reg.creep_trigger_mode),
    .permit  (permit),
    .src     (creep_src),
    .sel     (st_reg.creep_source_select),
    .mask    (creep_mask)
  );

  cfs_sum_clamp #(.N(cfs_pkg::N_CREEP)) u_creep_sum (
    .act (creep_mask),
    .val (st_reg.creep_values),
    .sum (creep_sum)
  );

  cfs_sum_clamp #(.N(cfs_pkg::N_FIX)) u_fix_sum (
    .act (fix_live),
    .val (st_reg.fixed_setpoint_values),
    .sum (fix_sum)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Registers, sample timer, creep sequence and setpoint selection. A register
  // write and a sample tick in the same cycle are independent: writes only
  // touch configuration, the tick only touches runtime state.
  always_comb
  begin
    logic [3:0] ci;
    logic [3:0] fi;
    st_next = st_reg;
    ci = tbl_index(reg_addr, cfs_pkg::OFS_CREEP_VAL, 4'(cfs_pkg::N_CREEP));
    fi = tbl_index(reg_addr, cfs_pkg::OFS_FIX_VAL, 4'(cfs_pkg::N_FIX));

    // Free-running sample timer.
    st_next.tick_cnt = tick ? 8'h00 : st_reg.tick_cnt + 8'h01;

    // Register writes.
    if (reg_wr)
    begin
      case (reg_addr)
        cfs_pkg::OFS_CTRL:
        begin
          st_next.creep_trigger_mode = reg_wdata[cfs_pkg::CTRL_MODE_BIT];
          st_next.creep_latch_permit_select = reg_wdata[cfs_pkg::CTRL_PSEL_LSB +: 2];
        end
        cfs_pkg::OFS_CREEP_SEL: st_next.creep_source_select = reg_wdata[cfs_pkg::N_CREEP-1:0];
        cfs_pkg::OFS_FIX_SEL:   st_next.setpoint_source_select = reg_wdata[cfs_pkg::N_FIX-1:0];
        cfs_pkg::OFS_BYP_SEL:   st_next.fixed_ramp_bypass_select = reg_wdata[cfs_pkg::N_FIX-1:0];
        default:
        begin
          if (ci != 4'hF)
            st_next.creep_values[ci[1:0]] = reg_wdata[cfs_pkg::SP_W-1:0];
          if (fi != 4'hF)
            st_next.fixed_setpoint_values[fi] = reg_wdata[cfs_pkg::SP_W-1:0];
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    st_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        cfs_pkg::OFS_CTRL:
        begin
          st_next.rdata[cfs_pkg::CTRL_MODE_BIT] = st_reg.creep_trigger_mode;
          st_next.rdata[cfs_pkg::CTRL_PSEL_LSB +: 2] = st_reg.creep_latch_permit_select;
        end
        cfs_pkg::OFS_CREEP_SEL: st_next.rdata[cfs_pkg::N_CREEP-1:0] = st_reg.creep_source_select;
        cfs_pkg::OFS_FIX_SEL:   st_next.rdata[cfs_pkg::N_FIX-1:0] = st_reg.setpoint_source_select;
        cfs_pkg::OFS_BYP_SEL:   st_next.rdata[cfs_pkg::N_FIX-1:0] = st_reg.fixed_ramp_bypass_select;
        cfs_pkg::OFS_STATUS:
        begin
          st_next.rdata[cfs_pkg::ST_REQ_BIT] = creep_req;
          st_next.rdata[cfs_pkg::ST_FIX_BIT] = fix_on;
          st_next.rdata[cfs_pkg::ST_BYP_BIT] = st_reg.bypass;
          st_next.rdata[cfs_pkg::ST_SWON_BIT] = st_reg.swon;
          st_next.rdata[cfs_pkg::ST_STATE_LSB +: 2] = st_reg.state;
          st_next.rdata[cfs_pkg::ST_MASK_LSB +: cfs_pkg::N_FIX] = st_reg.fix_mask;
        end
        cfs_pkg::OFS_SETPOINT:  st_next.rdata[cfs_pkg::SP_W-1:0] = st_reg.setpoint;
        default:
        begin
          if (ci != 4'hF)
            st_next.rdata[cfs_pkg::SP_W-1:0] = st_reg.creep_values[ci[1:0]];
          if (fi != 4'hF)
            st_next.rdata[cfs_pkg::SP_W-1:0] = st_reg.fixed_setpoint_values[fi];
        end
      endcase
    end

    // Runtime state moves only on the sample tick.
    if (tick)
    begin
      st_next.fix_mask = fix_live;
      case (st_reg.state)
        cfs_pkg::ST_IDLE:
        begin
          if (creep_req && creep_ok && switched_off_ready_state)
          begin
            st_next.state = cfs_pkg::ST_START;
            st_next.disable_ctl = 1'b0;
            st_next.open_k = 1'b0;
          end
          else if (creep_req && creep_ok)
            st_next.state = cfs_pkg::ST_RUN;
        end
        cfs_pkg::ST_START:
        begin
          if (!creep_req || !operation_enable)
            st_next.state = cfs_pkg::ST_STOP;
          else if (drive_running)
            st_next.state = cfs_pkg::ST_RUN;
        end
        cfs_pkg::ST_RUN:
        begin
          if (creep_req && operation_enable)
            st_next.state = cfs_pkg::ST_RUN;
          else if (switch_on_cmd && drive_running && operation_enable)
            st_next.state = cfs_pkg::ST_IDLE;
          else
            st_next.state = cfs_pkg::ST_STOP;
        end
        cfs_pkg::ST_STOP:
        begin
          if (below_min_speed)
          begin
            st_next.state = cfs_pkg::ST_IDLE;
            st_next.disable_ctl = 1'b1;
            st_next.open_k = 1'b1;
          end
        end
        default: st_next.state = cfs_pkg::ST_IDLE;
      endcase

      // Switch-on is held while creep starts from off-ready or creeps on without switch_on_cmd.
      st_next.swon = (st_next.state == cfs_pkg::ST_START) ||
                     (st_next.state == cfs_pkg::ST_RUN && !switch_on_cmd);

      // Creep outranks fixed setpoints, which outrank the main setpoint.
      if (st_next.state == cfs_pkg::ST_START || st_next.state == cfs_pkg::ST_RUN)
        st_next.setpoint = creep_sum;
      else if (st_next.state == cfs_pkg::ST_STOP)
        st_next.setpoint = 16'h0000;
      else if (|st_next.fix_mask)
        st_next.setpoint = fix_sum;
      else
        st_next.setpoint = main_setpoint_input;
      st_next.bypass = |(st_next.fix_mask & st_reg.fixed_ramp_bypass_select) &&
                       st_next.state == cfs_pkg::ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.state <= cfs_pkg::ST_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata       = st_reg.rdata;
  assign setpoint_out    = st_reg.setpoint;
  assign ramp_bypass     = st_reg.bypass;
  assign creep_switch_on = st_reg.swon;
  assign ctrl_disable    = st_reg.disable_ctl;
  assign contactor_open  = st_reg.open_k;
  assign creep_active    = (st_reg.state == cfs_pkg::ST_START) || (st_reg.state == cfs_pkg::ST_RUN);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_start_switch_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_reg.state == cfs_pkg::ST_IDLE && creep_req && creep_ok && switched_off_ready_state
    |=> creep_switch_on && setpoint_out == $past(creep_sum)) else $error("no switch-on");
  chk_run_creep_sp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_reg.state == cfs_pkg::ST_RUN && creep_req && operation_enable
    |=> setpoint_out == $past(creep_sum)) else $error("creep setpoint missing");
  chk_stop_contactor: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_reg.state == cfs_pkg::ST_STOP && below_min_speed
    |=> ctrl_disable && contactor_open && !creep_active) else $error("no shutdown");
  chk_creep_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(creep_active) |-> $past(operation_enable)) else $error("creep without enable");
  chk_fixed_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && !creep_req && st_reg.state == cfs_pkg::ST_IDLE && |(fix_src & st_reg.setpoint_source_select)
    |=> fix_on && setpoint_out == $past(fix_sum)) else $error("fixed sum not routed");
  chk_main_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && !creep_req && st_reg.state == cfs_pkg::ST_IDLE && (fix_src & st_reg.setpoint_source_select) == '0
    |=> setpoint_out == $past(main_setpoint_input)) else $error("main not routed");
  chk_sum_band: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $signed(fix_sum) <= 16'sh4000 && $signed(fix_sum) >= -16'sh4000) else $error("sum out of band");
  chk_bypass_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ramp_bypass |-> fix_on && (st_reg.fix_mask & st_reg.fixed_ramp_bypass_select) != '0)
    else $error("bypass without source");
  chk_tick_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(tick) |-> $stable(setpoint_out) && $stable(ramp_bypass)) else $error("update off tick");
  chk_creep_band: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $signed(creep_sum) <= 16'sh4000 && $signed(creep_sum) >= -16'sh4000)
    else $error("creep sum out of band");
  chk_creep_return: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_reg.state == cfs_pkg::ST_RUN && !creep_req && switch_on_cmd && drive_running
    && operation_enable && fix_live == '0
    |=> !creep_active && setpoint_out == $past(main_setpoint_input)) else $error("no return to main");

endmodule
`default_nettype wire

/* File: logic/cfs_pkg.sv */
// Constants, register map and state types for the creep and fixed-setpoint selector.
// Assumes a 125 MHz system clock and a 16-bit signed setpoint where 100% is 0x2000.
//
// Behaviour
// - Level mode: creep requested exactly while a selected creep source is high.
// - Edge mode: rising source edge latches creep, only while latch permit is high.
// - Edge mode: latched creep clears whenever the latch permit goes low.
// - Creep in off-ready state requests switch-on and feeds creep setpoint through ramp.
// - Creep while running hands creep setpoint to the ramp generator.
// - Creep withdrawn without switch-on: disable controller, open contactor below minimum speed.
// - Creep withdrawn while running conditions hold: return to operating setpoint.
// - Fixed setpoints come from eight indexed sources plus two extra sources.
// - Each fixed source has its own configurable setpoint value.
// - Active fixed setpoints are added and saturated to plus or minus 200 percent.
// - An active fixed source marked for bypass forces zero ramp times while the creep sequence is idle.
// - Any active fixed source replaces the main setpoint with the fixed sum.
// - With all fixed sources low the main setpoint is routed through again.
// - Several active creep sources have their creep setpoints added.
// - Creep only starts in off-ready or running state with operation enable.
package cfs_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned N_CREEP          = 4;
  localparam int unsigned N_IDX            = 8;
  localparam int unsigned N_FIX            = 10;
  localparam int unsigned SP_W             = 16;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned SAMPLE_PERIOD_NS = 1000;
  localparam int unsigned SAMPLE_CYC       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  SAMPLE_LAST      = 8'(SAMPLE_CYC - 1);

  // Saturation limits: 100% is 0x2000, so 200% is 0x4000.
  localparam logic signed [19:0] SP_MAX = 20'sh0_4000;
  localparam logic signed [19:0] SP_MIN = -20'sh0_4000;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CREEP_SEL = 8'h04;
  localparam logic [7:0] OFS_FIX_SEL   = 8'h08;
  localparam logic [7:0] OFS_BYP_SEL   = 8'h0C;
  localparam logic [7:0] OFS_CREEP_VAL = 8'h10;
  localparam logic [7:0] OFS_FIX_VAL   = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h48;
  localparam logic [7:0] OFS_SETPOINT  = 8'h4C;

  // Control register fields.
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_PSEL_LSB = 4;

  // Status register fields.
  localparam int unsigned ST_REQ_BIT    = 0;
  localparam int unsigned ST_FIX_BIT    = 1;
  localparam int unsigned ST_BYP_BIT    = 2;
  localparam int unsigned ST_SWON_BIT   = 3;
  localparam int unsigned ST_STATE_LSB  = 4;
  localparam int unsigned ST_MASK_LSB   = 8;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN,
    ST_STOP
  } cfs_state_e;

endpackage

/* File: logic/cfs_sum_clamp.sv */
// Adds the setpoint values of all active sources and saturates the total.
// Assumes values are 16-bit signed; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module cfs_sum_clamp #(
  parameter int unsigned N = 10
) (
  input  wire logic [N-1:0]                      act,  // Active source mask.
  input  wire logic [N-1:0][cfs_pkg::SP_W-1:0]   val,  // Per-source setpoints.
  output logic      [cfs_pkg::SP_W-1:0]          sum   // Saturated sum.
);

  // Partial sums carry four extra bits so ten full-scale values cannot wrap.
  logic signed [19:0] part [0:N];

  assign part[0] = 20'sh0_0000;

  // One adder stage per source.
  for (genvar i = 0; i < N; i++)
  begin : g_add
    assign part[i+1] = part[i] + (act[i] ? $signed({{4{val[i][15]}}, val[i]}) : 20'sh0_0000);
  end

  // Saturate to the 200 percent band.
  always_comb
  begin
    if (part[N] > cfs_pkg::SP_MAX)
      sum = cfs_pkg::SP_MAX[15:0];
    else if (part[N] < cfs_pkg::SP_MIN)
      sum = cfs_pkg::SP_MIN[15:0];
    else
      sum = part[N][15:0];
  end

endmodule
`default_nettype wire

/* File: logic/cfs_creep_req.sv */
// Creep request logic: level or edge triggered, with latch and permit-driven clear.
// Assumes a one-cycle sample tick from the parent; state only moves on that tick.
`timescale 1ns/1ps
`default_nettype none
module cfs_creep_req (
  input  wire logic                          clk_sys,   // System clock.
  input  wire logic                          sys_rst,   // Async reset, active high.
  input  wire logic                          tick,      // Sample period strobe.
  input  wire logic                          mode,      // 0 level, 1 edge.
  input  wire logic                          permit,    // Latch permit level.
  input  wire logic [cfs_pkg::N_CREEP-1:0]   src,       // Creep source inputs.
  input  wire logic [cfs_pkg::N_CREEP-1:0]   sel,       // Enabled sources.
  output logic      [cfs_pkg::N_CREEP-1:0]   mask       // Requesting sources.
);

  typedef struct packed {
    logic [cfs_pkg::N_CREEP-1:0] prev;
    logic [cfs_pkg::N_CREEP-1:0] mask;
  } cfs_creep_s;

  cfs_creep_s st_reg;
  cfs_creep_s st_next;
  logic [cfs_pkg::N_CREEP-1:0] live;

  assign live = src & sel;
  assign mask = st_reg.mask;

  // Each source keeps its own latch so the creep sum follows exactly who asked.
  always_comb
  begin
    st_next = st_reg;
    if (tick)
    begin
      st_next.prev = live;
      if (!mode)
        st_next.mask = live;
      else if (!permit)
        st_next.mask = '0;
      else
        st_next.mask = st_reg.mask | (live & ~st_reg.prev);
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  chk_level_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && !mode |=> mask == $past(live)) else $error("level mode mask wrong");
  chk_edge_permit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(mode) && ((mask & ~$past(mask)) != '0) |-> $past(permit) && $past(tick))
    else $error("latch set without permit");
  chk_permit_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && mode && !permit |=> mask == '0) else $error("latch not cleared");

endmodule
`default_nettype wire

/* File: test/cfs_drive_model.sv */
// Behavioural ramp and on/off sequencer standing behind the selector.
// Assumes the selector's requests are registered levels on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module cfs_drive_model (
  input  wire logic clk_sys,                  // System clock.
  input  wire logic sys_rst,                  // Async reset, active high.
  input  wire logic run_req,                  // Switch-on request, creep or external.
  output logic      switched_off_ready_state, // Drive off and ready.
  output logic      drive_running,            // Operation state.
  output logic      below_min_speed           // Speed under minimum.
);
  logic [4:0] speed_reg;
  // Speed moves one step a cycle, so start and stop take many cycles, not one.
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      speed_reg <= 5'h00;
    else if (run_req && speed_reg != 5'h1F)
      speed_reg <= speed_reg + 5'h01;
    else if (!run_req && speed_reg != 5'h00)
      speed_reg <= speed_reg - 5'h01;
  // State levels derived from the speed.
  assign drive_running            = (speed_reg == 5'h1F);
  assign below_min_speed          = (speed_reg < 5'h04);
  assign switched_off_ready_state = (speed_reg == 5'h00);
endmodule
`default_nettype wire

/* File: test/cfs_select_tb_top.sv */
// Self-checking bench for the creep and fixed-setpoint selector.
// Assumes a 125-cycle sample period; waits are counted in whole periods.
`timescale 1ns/1ps
`default_nettype none
module cfs_select_tb_top;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd_val;
  logic [3:0] creep_src = 4'h0, creep_permit_in = 4'h0;
  logic [7:0] fixed_src_idx = 8'h00;
  logic xa = 1'b0, xb = 1'b0, op_en = 1'b1, sw_cmd = 1'b0;
  logic [15:0] main_sp = 16'h1234, setpoint_out;
  logic off_rdy, running, below_min, ramp_bypass, creep_switch_on;
  logic ctrl_disable, contactor_open, creep_active;
  int n_fail = 0, comparisons = 0;
  initial forever #4 clk_sys = ~clk_sys;
  cfs_select u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .creep_src(creep_src), .creep_permit_in(creep_permit_in), .fixed_src_idx(fixed_src_idx),
    .extra_fixed_source_a(xa), .extra_fixed_source_b(xb), .main_setpoint_input(main_sp),
    .switched_off_ready_state(off_rdy), .drive_running(running), .operation_enable(op_en),
    .switch_on_cmd(sw_cmd), .below_min_speed(below_min), .setpoint_out(setpoint_out),
    .ramp_bypass(ramp_bypass), .creep_switch_on(creep_switch_on),
    .ctrl_disable(ctrl_disable), .contactor_open(contactor_open), .creep_active(creep_active));
  cfs_drive_model u_drive (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .run_req(creep_switch_on | sw_cmd), .switched_off_ready_state(off_rdy),
    .drive_running(running), .below_min_speed(below_min));
  // Register access: one-cycle strobes; read data taken in the cycle after.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n * 125) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about 40 sample periods.
  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr(8'h20, 32'h0000_3000);
    wr(8'h44, 32'h0000_3000);
    wr(8'h08, 32'h0000_0201);
    wr(8'h0C, 32'h0000_0001);
    rd(8'h44); chk_word(rd_val, 32'h0000_3000);
    rd(8'hF0); chk_word(rd_val, 32'h0000_0000);
    fixed_src_idx <= 8'h01; xb <= 1'b1;
    ticks(3);
    chk_word({16'h0, setpoint_out}, 32'h0000_4000);
    chk_bit(ramp_bypass, 1'b1);
    fixed_src_idx <= 8'h00;
    ticks(3);
    chk_word({16'h0, setpoint_out}, 32'h0000_3000);
    chk_bit(ramp_bypass, 1'b0);
    xb <= 1'b0;
    ticks(3);
    chk_word({16'h0, setpoint_out}, 32'h0000_1234);
    $display("test fixed setpoint done");
    wr(8'h10, 32'h0000_0100);
    wr(8'h14, 32'h0000_0200);
    wr(8'h04, 32'h0000_0003);
    creep_src <= 4'h3;
    ticks(3);
    chk_bit(creep_switch_on, 1'b1);
    chk_bit(creep_active, 1'b1);
    chk_word({16'h0, setpoint_out}, 32'h0000_0300);
    ticks(2);
    chk_bit(running, 1'b1);
    chk_word({16'h0, setpoint_out}, 32'h0000_0300);
    creep_src <= 4'h0;
    ticks(5);
    chk_bit(ctrl_disable, 1'b1);
    chk_bit(contactor_open, 1'b1);
    chk_bit(creep_active, 1'b0);
    chk_word({16'h0, setpoint_out}, 32'h0000_1234);
    $display("test creep level done");
    wr(8'h00, 32'h0000_0001);
    creep_src <= 4'h1;
    ticks(3);
    rd(8'h48); chk_bit(rd_val[0], 1'b0);
    creep_src <= 4'h0; creep_permit_in <= 4'h1;
    ticks(2);
    creep_src <= 4'h1;
    ticks(3);
    rd(8'h48); chk_bit(rd_val[0], 1'b1);
    creep_permit_in <= 4'h0;
    ticks(3);
    rd(8'h48); chk_bit(rd_val[0], 1'b0);
    $display("test creep edge done");
    creep_src <= 4'h0; sw_cmd <= 1'b1;
    wr(8'h00, 32'h0000_0000);
    ticks(1);
    creep_src <= 4'h1;
    ticks(3);
    chk_bit(creep_active, 1'b1);
    chk_bit(creep_switch_on, 1'b0);
    chk_word({16'h0, setpoint_out}, 32'h0000_0100);
    creep_src <= 4'h0;
    ticks(3);
    chk_bit(creep_active, 1'b0);
    chk_word({16'h0, setpoint_out}, 32'h0000_1234);
    $display("test creep return done");
    give_verdict();
  end
endmodule
`default_nettype wire
